// >>> rtl/p0pmm_consts.vh
// Overview of operation
// R1 - Mode bits 9:8 pick 00 plain input, 01 input with pull-up, 10 input with pull-down, 11 output without pulls.
// R2 - After reset the mode bits of every pin hold 2, so each pin starts as an input with pull-down.
// R3 - While a pin is routed to the analog converter its mode bits are ignored.
// R4 - The function bits 4:0 reset to 0, and 0 makes the pin a plain port bit steered by the mode bits.
// R5 - Codes 1 to 4 route serial A receive, serial A transmit, serial B receive, serial B transmit.
// R6 - Codes 5 to 8 route the sync serial data in, data out, clock and enable.
// R7 - Code 9 routes the two-wire clock line and code 10 the two-wire data line.
// R8 - Codes 11 to 14 route infrared receive and transmit of serial A, then of serial B.
// R9 - Code 15 joins the pin to the analog converter, and only port 0 pins 0 to 3 accept it.
// R10 - Codes 16 and 17 drive pulse-width outputs 0 and 1; codes 23 to 25 drive outputs 2 to 4.
// R11 - Code 18 drives radio link diagnostics, accepted only on port 0 pins 0 to 7.
// R12 - Codes 19 to 22 route clear-to-send and request-to-send of serial A, then of serial B.
// R13 - An input picked on several pins comes from the lowest pin, and port 0 beats port 1.
// R14 - Codes 26 to 31 act as code 0, and reserved bits read zero and ignore writes.
// R15 - A peripheral drives a pin only while selected, and an unselected input sees its idle level.
`ifndef P0PMM_CONSTS_VH
`define P0PMM_CONSTS_VH

// Register offsets
`define P0PMM_PIN3_MODE_OFFSET 32'h5000300c
`define P0PMM_PIN4_MODE_OFFSET 32'h5000300e
`define P0PMM_PIN5_MODE_OFFSET 32'h50003010
`define P0PMM_PIN6_MODE_OFFSET 32'h50003012
`define P0PMM_PIN_LEVEL_OFFSET 32'h50003040

// Mode register fields and reset values
`define P0PMM_PULL_DIRECTION_SELECT_MSB 9
`define P0PMM_PULL_DIRECTION_SELECT_LSB 8
`define P0PMM_FUNC_MSB 4
`define P0PMM_FUNC_LSB 0
`define P0PMM_PULL_DIRECTION_SELECT_RESET 2'h2
`define P0PMM_FUNC_RESET 5'h00

// Pull and direction codes
`define P0PMM_PULL_DIRECTION_SELECT_INPUT 2'h0
`define P0PMM_PULL_DIRECTION_SELECT_PULL_UP 2'h1
`define P0PMM_PULL_DIRECTION_SELECT_PULL_DOWN 2'h2
`define P0PMM_PULL_DIRECTION_SELECT_OUTPUT 2'h3

// Function codes
`define P0PMM_FN_PORT 5'h00
`define P0PMM_FN_SA_RX 5'h01
`define P0PMM_FN_SA_TX 5'h02
`define P0PMM_FN_SB_RX 5'h03
`define P0PMM_FN_SB_TX 5'h04
`define P0PMM_FN_SS_DI 5'h05
`define P0PMM_FN_SS_DO 5'h06
`define P0PMM_FN_SS_CLK 5'h07
`define P0PMM_FN_SS_EN 5'h08
`define P0PMM_FN_TW_CLK 5'h09
`define P0PMM_FN_TW_DATA 5'h0a
`define P0PMM_FN_SA_IR_RX 5'h0b
`define P0PMM_FN_SA_IR_TX 5'h0c
`define P0PMM_FN_SB_IR_RX 5'h0d
`define P0PMM_FN_SB_IR_TX 5'h0e
`define P0PMM_FN_ANALOG 5'h0f
`define P0PMM_FN_PW0 5'h10
`define P0PMM_FN_PW1 5'h11
`define P0PMM_FN_DIAG 5'h12
`define P0PMM_FN_SA_CTS 5'h13
`define P0PMM_FN_SA_RTS 5'h14
`define P0PMM_FN_SB_CTS 5'h15
`define P0PMM_FN_SB_RTS 5'h16
`define P0PMM_FN_PW2 5'h17
`define P0PMM_FN_PW3 5'h18
`define P0PMM_FN_PW4 5'h19
`define P0PMM_FN_LAST 5'h19

// Pin limits for restricted codes
`define P0PMM_ANALOG_PIN_LIMIT 3
`define P0PMM_DIAG_PIN_LIMIT 7

// Peripheral input channels
`define P0PMM_CH_SA_RX 0
`define P0PMM_CH_SB_RX 1
`define P0PMM_CH_SS_DI 2
`define P0PMM_CH_SS_CLK 3
`define P0PMM_CH_SS_EN 4
`define P0PMM_CH_TW_CLK 5
`define P0PMM_CH_TW_DATA 6
`define P0PMM_CH_SA_IR_RX 7
`define P0PMM_CH_SB_IR_RX 8
`define P0PMM_CH_SA_CTS 9
`define P0PMM_CH_SB_CTS 10
`define P0PMM_CHANNELS 11
`define P0PMM_INPUT_IDLE 11'h673

`endif

// >>> rtl/p0pmm_mode_reg.v
`timescale 1ns/10ps
`default_nettype none
`include "p0pmm_consts.vh"

module p0pmm_mode_reg (
  input wire i_clock,
  input wire i_reset,
  input wire i_write_enable,
  input wire [15:0] i_write_data,
  output reg [1:0] o_pull_direction,
  output reg [4:0] o_function,
  output wire [15:0] o_value
);

  // Only the two fields are stored; reserved bits never get a flop
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_pull_direction <= `P0PMM_PULL_DIRECTION_SELECT_RESET; // R2
      o_function <= `P0PMM_FUNC_RESET; // R4
    end else if (i_write_enable) begin
      o_pull_direction <= i_write_data[`P0PMM_PULL_DIRECTION_SELECT_MSB:`P0PMM_PULL_DIRECTION_SELECT_LSB];
      o_function <= i_write_data[`P0PMM_FUNC_MSB:`P0PMM_FUNC_LSB];
    end
  end

  // Reserved bits read as zero
  assign o_value = {6'h00, o_pull_direction, 3'h0, o_function}; // R14

endmodule
`default_nettype wire

// >>> rtl/p0pmm_pin_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "p0pmm_consts.vh"

module p0pmm_pin_ctrl #(
  parameter PIN_INDEX = 3
) (
  input wire i_clock,
  input wire i_reset,
  input wire [4:0] i_function,
  input wire [1:0] i_pull_direction,
  input wire i_port_out,
  input wire [31:0] i_drive_value,
  input wire [31:0] i_drive_en,
  output wire [4:0] o_effective_function,
  output reg o_pad_out,
  output reg o_pad_oe_n,
  output reg o_pull_up,
  output reg o_pull_down,
  output reg o_analog
);

  reg [4:0] effective;
  reg next_drive;
  reg next_value;
  reg input_side;

  // Codes this pin cannot take fall back to plain port use
  always @* begin
    effective = i_function;
    if (i_function > `P0PMM_FN_LAST)
      effective = `P0PMM_FN_PORT; // R14
    if (i_function == `P0PMM_FN_ANALOG && PIN_INDEX > `P0PMM_ANALOG_PIN_LIMIT)
      effective = `P0PMM_FN_PORT; // R9
    if (i_function == `P0PMM_FN_DIAG && PIN_INDEX > `P0PMM_DIAG_PIN_LIMIT)
      effective = `P0PMM_FN_PORT; // R11
  end

  assign o_effective_function = effective;

  // Drive source and pulls for the chosen function
  always @* begin
    if (effective == `P0PMM_FN_PORT) begin
      next_drive = (i_pull_direction == `P0PMM_PULL_DIRECTION_SELECT_OUTPUT); // R1 R4
      next_value = i_port_out;
    end else if (effective == `P0PMM_FN_ANALOG) begin
      next_drive = 1'b0; // R3
      next_value = 1'b0;
    end else begin
      next_drive = i_drive_en[effective]; // R15
      next_value = i_drive_value[effective];
    end
    input_side = !next_drive && effective != `P0PMM_FN_ANALOG;
  end

  // Registered pad controls; analog mode kills pulls whatever the mode bits say
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_pad_out <= 1'b0;
      o_pad_oe_n <= 1'b1;
      o_pull_up <= 1'b0;
      o_pull_down <= 1'b1; // R2
      o_analog <= 1'b0;
    end else begin
      o_pad_out <= next_value;
      o_pad_oe_n <= !next_drive;
      o_pull_up <= input_side && i_pull_direction == `P0PMM_PULL_DIRECTION_SELECT_PULL_UP; // R1
      o_pull_down <= input_side && i_pull_direction == `P0PMM_PULL_DIRECTION_SELECT_PULL_DOWN; // R1
      o_analog <= (effective == `P0PMM_FN_ANALOG); // R3 R9
    end
  end

endmodule
`default_nettype wire

// >>> rtl/p0pmm_mux.v
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "p0pmm_consts.vh"

module p0pmm_mux #(
  parameter PINS = 4,
  parameter PIN_BASE = 3,
  parameter CHANNELS = `P0PMM_CHANNELS,
  parameter [`P0PMM_CHANNELS-1:0] INPUT_IDLE = `P0PMM_INPUT_IDLE
) (
  input wire i_clock,
  input wire i_reset,
  // Register port
  input wire [31:0] i_address,
  input wire [15:0] i_write_data,
  input wire i_write,
  input wire i_read,
  output reg [15:0] o_read_data,
  // Pads
  input wire [3:0] i_pad_in,
  input wire [3:0] i_port_out,
  output wire [3:0] o_pad_out,
  output wire [3:0] o_pad_oe_n,
  output wire [3:0] o_pad_pull_up,
  output wire [3:0] o_pad_pull_down,
  output wire [3:0] o_pad_analog,
  // Peripheral outputs toward the pins
  input wire i_serial_a_transmit,
  input wire i_serial_b_transmit,
  input wire i_sync_serial_data_output,
  input wire i_sync_serial_clock_out,
  input wire i_sync_serial_clock_oe,
  input wire i_sync_serial_enable_out,
  input wire i_sync_serial_enable_oe,
  input wire i_two_wire_clock_low,
  input wire i_two_wire_data_low,
  input wire i_serial_a_infrared_transmit,
  input wire i_serial_b_infrared_transmit,
  input wire i_pulse_width_out_zero,
  input wire i_pulse_width_out_one,
  input wire i_pulse_width_out_two,
  input wire i_pulse_width_out_three,
  input wire i_pulse_width_out_four,
  input wire [7:0] i_radio_link_diagnostic,
  input wire i_serial_a_request_to_send_n,
  input wire i_serial_b_request_to_send_n,
  // Claims from higher priority pins and toward lower ones
  input wire [10:0] i_higher_claim,
  input wire [10:0] i_higher_level,
  output reg [10:0] o_claim,
  // Peripheral inputs from the pins
  output wire o_serial_a_receive,
  output wire o_serial_b_receive,
  output wire o_sync_serial_data_input,
  output wire o_sync_serial_clock_in,
  output wire o_sync_serial_enable_in,
  output wire o_two_wire_clock_in,
  output wire o_two_wire_data_in,
  output wire o_serial_a_infrared_receive,
  output wire o_serial_b_infrared_receive,
  output wire o_serial_a_clear_to_send_n,
  output wire o_serial_b_clear_to_send_n
);

  // Register address of each pin's mode word
  function [31:0] p0pmm_mode_offset;
    input [2:0] pin;
    begin
      case (pin)
        3'h0: p0pmm_mode_offset = `P0PMM_PIN3_MODE_OFFSET;
        3'h1: p0pmm_mode_offset = `P0PMM_PIN4_MODE_OFFSET;
        3'h2: p0pmm_mode_offset = `P0PMM_PIN5_MODE_OFFSET;
        3'h3: p0pmm_mode_offset = `P0PMM_PIN6_MODE_OFFSET;
        default: p0pmm_mode_offset = 32'hffffffff;
      endcase
    end
  endfunction

  // Function code that feeds each peripheral input channel
  function [4:0] p0pmm_channel_code;
    input [3:0] channel;
    begin
      case (channel)
        4'h0: p0pmm_channel_code = `P0PMM_FN_SA_RX; // R5
        4'h1: p0pmm_channel_code = `P0PMM_FN_SB_RX; // R5
        4'h2: p0pmm_channel_code = `P0PMM_FN_SS_DI; // R6
        4'h3: p0pmm_channel_code = `P0PMM_FN_SS_CLK; // R6
        4'h4: p0pmm_channel_code = `P0PMM_FN_SS_EN; // R6
        4'h5: p0pmm_channel_code = `P0PMM_FN_TW_CLK; // R7
        4'h6: p0pmm_channel_code = `P0PMM_FN_TW_DATA; // R7
        4'h7: p0pmm_channel_code = `P0PMM_FN_SA_IR_RX; // R8
        4'h8: p0pmm_channel_code = `P0PMM_FN_SB_IR_RX; // R8
        4'h9: p0pmm_channel_code = `P0PMM_FN_SA_CTS; // R12
        4'ha: p0pmm_channel_code = `P0PMM_FN_SB_CTS; // R12
        default: p0pmm_channel_code = 5'h1f;
      endcase
    end
  endfunction

  wire [PINS*2-1:0] pull_direction_select;
  wire [PINS*5-1:0] pin_function_select;
  wire [PINS*5-1:0] effective_function;
  wire [PINS*16-1:0] mode_value;
  reg [31:0] drive_value;
  reg [31:0] drive_en;
  reg [CHANNELS-1:0] next_claim;
  reg [CHANNELS-1:0] next_level;
  reg [CHANNELS-1:0] peripheral_level;
  reg [15:0] next_read_data;
  integer ch;
  integer p;
  integer q;

  // Per-pin mode word and pad control
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin
      p0pmm_mode_reg mode (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_write_enable(i_write && i_address == p0pmm_mode_offset(g)),
        .i_write_data(i_write_data),
        .o_pull_direction(pull_direction_select[g*2 +: 2]),
        .o_function(pin_function_select[g*5 +: 5]),
        .o_value(mode_value[g*16 +: 16])
      );

      p0pmm_pin_ctrl #(
        .PIN_INDEX(PIN_BASE + g)
      ) ctrl (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_function(pin_function_select[g*5 +: 5]),
        .i_pull_direction(pull_direction_select[g*2 +: 2]),
        .i_port_out(i_port_out[g]),
        // Diagnostic slot carries this pin's own bit of the diagnostic bus
        .i_drive_value({drive_value[31:19], i_radio_link_diagnostic[PIN_BASE + g],
          drive_value[17:0]}), // R11
        .i_drive_en(drive_en),
        .o_effective_function(effective_function[g*5 +: 5]),
        .o_pad_out(o_pad_out[g]),
        .o_pad_oe_n(o_pad_oe_n[g]),
        .o_pull_up(o_pad_pull_up[g]),
        .o_pull_down(o_pad_pull_down[g]),
        .o_analog(o_pad_analog[g])
      );
    end
  endgenerate

  // Output table indexed by function code; input-only codes never drive
  always @* begin
    drive_value = 32'h00000000;
    drive_en = 32'h00000000;
    drive_value[`P0PMM_FN_SA_TX] = i_serial_a_transmit; // R5
    drive_en[`P0PMM_FN_SA_TX] = 1'b1; // R5
    drive_value[`P0PMM_FN_SB_TX] = i_serial_b_transmit; // R5
    drive_en[`P0PMM_FN_SB_TX] = 1'b1; // R5
    drive_value[`P0PMM_FN_SS_DO] = i_sync_serial_data_output; // R6
    drive_en[`P0PMM_FN_SS_DO] = 1'b1; // R6
    // Clock and enable drive only when the sync serial block masters them
    drive_value[`P0PMM_FN_SS_CLK] = i_sync_serial_clock_out; // R6
    drive_en[`P0PMM_FN_SS_CLK] = i_sync_serial_clock_oe; // R6
    drive_value[`P0PMM_FN_SS_EN] = i_sync_serial_enable_out; // R6
    drive_en[`P0PMM_FN_SS_EN] = i_sync_serial_enable_oe; // R6
    // Two-wire lines are open drain: pull low or let go
    drive_value[`P0PMM_FN_TW_CLK] = 1'b0; // R7
    drive_en[`P0PMM_FN_TW_CLK] = i_two_wire_clock_low; // R7
    drive_value[`P0PMM_FN_TW_DATA] = 1'b0; // R7
    drive_en[`P0PMM_FN_TW_DATA] = i_two_wire_data_low; // R7
    drive_value[`P0PMM_FN_SA_IR_TX] = i_serial_a_infrared_transmit; // R8
    drive_en[`P0PMM_FN_SA_IR_TX] = 1'b1; // R8
    drive_value[`P0PMM_FN_SB_IR_TX] = i_serial_b_infrared_transmit; // R8
    drive_en[`P0PMM_FN_SB_IR_TX] = 1'b1; // R8
    drive_value[`P0PMM_FN_PW0] = i_pulse_width_out_zero; // R10
    drive_en[`P0PMM_FN_PW0] = 1'b1; // R10
    drive_value[`P0PMM_FN_PW1] = i_pulse_width_out_one; // R10
    drive_en[`P0PMM_FN_PW1] = 1'b1; // R10
    drive_value[`P0PMM_FN_PW2] = i_pulse_width_out_two; // R10
    drive_en[`P0PMM_FN_PW2] = 1'b1; // R10
    drive_value[`P0PMM_FN_PW3] = i_pulse_width_out_three; // R10
    drive_en[`P0PMM_FN_PW3] = 1'b1; // R10
    drive_value[`P0PMM_FN_PW4] = i_pulse_width_out_four; // R10
    drive_en[`P0PMM_FN_PW4] = 1'b1; // R10
    drive_value[`P0PMM_FN_SA_RTS] = i_serial_a_request_to_send_n; // R12
    drive_en[`P0PMM_FN_SA_RTS] = 1'b1; // R12
    drive_value[`P0PMM_FN_SB_RTS] = i_serial_b_request_to_send_n; // R12
    drive_en[`P0PMM_FN_SB_RTS] = 1'b1; // R12
    drive_en[`P0PMM_FN_DIAG] = 1'b1; // R11
  end

  // Priority resolution: walk pins downward so the lowest pin wins;
  // any claim from pins ahead of ours in the chain beats all of ours
  always @* begin
    next_claim = {CHANNELS{1'b0}};
    next_level = INPUT_IDLE; // R15
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin
      if (i_higher_claim[ch]) begin
        next_claim[ch] = 1'b1; // R13
        next_level[ch] = i_higher_level[ch]; // R13
      end else begin
        for (p = PINS - 1; p >= 0; p = p - 1) begin
          if (effective_function[p*5 +: 5] == p0pmm_channel_code(ch[3:0])) begin
            next_claim[ch] = 1'b1; // R13
            next_level[ch] = i_pad_in[p]; // R13
          end
        end
      end
    end
  end

  // Peripheral inputs and claims are registered
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_claim <= {CHANNELS{1'b0}};
      peripheral_level <= INPUT_IDLE; // R15
    end else begin
      o_claim <= next_claim;
      peripheral_level <= next_level;
    end
  end

  assign o_serial_a_receive = peripheral_level[`P0PMM_CH_SA_RX];
  assign o_serial_b_receive = peripheral_level[`P0PMM_CH_SB_RX];
  assign o_sync_serial_data_input = peripheral_level[`P0PMM_CH_SS_DI];
  assign o_sync_serial_clock_in = peripheral_level[`P0PMM_CH_SS_CLK];
  assign o_sync_serial_enable_in = peripheral_level[`P0PMM_CH_SS_EN];
  assign o_two_wire_clock_in = peripheral_level[`P0PMM_CH_TW_CLK];
  assign o_two_wire_data_in = peripheral_level[`P0PMM_CH_TW_DATA];
  assign o_serial_a_infrared_receive = peripheral_level[`P0PMM_CH_SA_IR_RX];
  assign o_serial_b_infrared_receive = peripheral_level[`P0PMM_CH_SB_IR_RX];
  assign o_serial_a_clear_to_send_n = peripheral_level[`P0PMM_CH_SA_CTS];
  assign o_serial_b_clear_to_send_n = peripheral_level[`P0PMM_CH_SB_CTS];

  // Read mux; unmapped addresses read zero
  always @* begin
    next_read_data = 16'h0000;
    for (q = 0; q < PINS; q = q + 1) begin
      if (i_address == p0pmm_mode_offset(q[2:0]))
        next_read_data = mode_value[q*16 +: 16]; // R14
    end
    if (i_address == `P0PMM_PIN_LEVEL_OFFSET)
      next_read_data = {8'h00, o_pad_analog, i_pad_in};
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_clock) begin
    if (i_reset)
      o_read_data <= 16'h0000;
    else if (i_read)
      o_read_data <= next_read_data;
    else
      o_read_data <= 16'h0000;
  end

endmodule
`default_nettype wire

// >>> sim/p0pmm_checker.sv
`timescale 1ns/10ps
`default_nettype none
module p0pmm_checker (
  input wire i_clock,
  input wire i_reset,
  input wire [31:0] i_address,
  input wire i_read,
  input wire [15:0] o_read_data,
  input wire [3:0] o_pad_oe_n,
  input wire [3:0] o_pad_pull_up,
  input wire [3:0] o_pad_pull_down,
  input wire [3:0] o_pad_analog,
  input wire [10:0] i_higher_claim,
  input wire [10:0] i_higher_level,
  input wire [10:0] o_claim,
  input wire o_serial_a_receive
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Address decode, compared one cycle late against the read answer
  wire is_mode = i_address inside {32'h5000300c, 32'h5000300e, 32'h50003010, 32'h50003012};
  wire is_known = is_mode || (i_address == 32'h50003040);

  AST_RESERVED_ZERO: assert property (
    $past(i_read) && $past(is_mode) |-> (o_read_data & 16'hfce0) == 16'h0000)
    else $error("reserved mode bits read nonzero");
  AST_UNMAPPED_ZERO: assert property (
    $past(i_read) && !$past(is_known) |-> o_read_data == 16'h0000)
    else $error("unmapped read returned data");
  // Reset itself is the cause here, so this one is not disabled by it
  AST_RESET_PADS: assert property (disable iff (1'b0)
    i_reset |=> o_pad_oe_n == 4'hf && o_pad_pull_down == 4'hf && o_pad_pull_up == 4'h0)
    else $error("pads not input with pull-down after reset");
  AST_ANALOG_PIN_LIMIT: assert property (
    o_pad_analog[3:1] == 3'h0)
    else $error("analog on a pin above 3");
  AST_ANALOG_NO_PULL: assert property (
    (o_pad_analog & (o_pad_pull_up | o_pad_pull_down | ~o_pad_oe_n)) == 4'h0)
    else $error("analog pin has pull or drive");
  AST_DRIVEN_NO_PULL: assert property (
    (~o_pad_oe_n & (o_pad_pull_up | o_pad_pull_down)) == 4'h0)
    else $error("driven pin has a pull");
  AST_ONE_PULL: assert property (
    (o_pad_pull_up & o_pad_pull_down) == 4'h0)
    else $error("both pulls on");
  AST_HIGHER_INPUT: assert property (
    i_higher_claim[0] |=> o_serial_a_receive == $past(i_higher_level[0]))
    else $error("higher pin did not win receive input");
  AST_CLAIM_CASCADE: assert property (
    ##1 (o_claim | ~$past(i_higher_claim)) == 11'h7ff)
    else $error("higher claim not passed on");

  COV_ANALOG: cover property (o_pad_analog[0]);
  COV_HIGHER: cover property (i_higher_claim[0] ##1 o_serial_a_receive);
  COV_MODE_READ: cover property (i_read && is_mode ##1 o_read_data != 16'h0000);
endmodule

bind p0pmm_mux p0pmm_checker p0pmm_checker_i (.i_clock, .i_reset, .i_address, .i_read,
  .o_read_data, .o_pad_oe_n, .o_pad_pull_up, .o_pad_pull_down, .o_pad_analog,
  .i_higher_claim, .i_higher_level, .o_claim, .o_serial_a_receive);
`default_nettype wire

// >>> sim/p0pmm_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module p0pmm_far_side (
  input wire i_clock,
  input wire [25:0] i_stir,
  input wire [3:0] i_ext_drive,
  input wire [3:0] i_ext_level,
  input wire [3:0] i_pad_out,
  input wire [3:0] i_pad_oe_n,
  input wire [3:0] i_pull_up,
  input wire [3:0] i_pull_down,
  output logic [3:0] o_pad_in,
  output logic [25:0] o_periph
);
  logic [3:0] last;
  initial begin
    o_periph = 26'h0;
    last = 4'h0;
  end
  // Peripherals refresh their outputs once a cycle
  always @(posedge i_clock) begin
    o_periph <= i_stir;
    last <= o_pad_in;
  end
  // Pad wire: chip drive, then board drive, then pulls; a floating pad flips
  // every cycle so a missing pull never reads as a steady level
  always @* begin
    for (int k = 0; k < 4; k++) begin
      if (!i_pad_oe_n[k]) o_pad_in[k] = i_pad_out[k];
      else if (i_ext_drive[k]) o_pad_in[k] = i_ext_level[k];
      else if (i_pull_up[k]) o_pad_in[k] = 1'b1;
      else if (i_pull_down[k]) o_pad_in[k] = 1'b0;
      else o_pad_in[k] = ~last[k];
    end
  end
endmodule
`default_nettype wire

// >>> sim/port0_pin_mode_mux_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "p0pmm_consts.vh"
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t got %h want %h", $time, got, exp); end end
module port0_pin_mode_mux_test;
  logic i_clock = 0, i_reset = 1, i_write = 0, i_read = 0;
  logic [31:0] i_address = 0;
  logic [15:0] i_write_data = 0, o_read_data;
  logic [3:0] i_pad_in, i_port_out = 0, o_pad_out, o_pad_oe_n, o_pad_pull_up;
  logic [3:0] o_pad_pull_down, o_pad_analog, ext_drive = 0, ext_level = 0;
  logic [10:0] i_higher_claim = 0, i_higher_level = 0, o_claim;
  logic [25:0] stir = 0, per;
  wire i_serial_a_transmit, i_serial_b_transmit, i_sync_serial_data_output;
  wire i_sync_serial_clock_out, i_sync_serial_clock_oe, i_sync_serial_enable_out;
  wire i_sync_serial_enable_oe, i_two_wire_clock_low, i_two_wire_data_low;
  wire i_serial_a_infrared_transmit, i_serial_b_infrared_transmit, i_pulse_width_out_zero;
  wire i_pulse_width_out_one, i_pulse_width_out_two, i_pulse_width_out_three;
  wire i_pulse_width_out_four, i_serial_a_request_to_send_n, i_serial_b_request_to_send_n;
  wire [7:0] i_radio_link_diagnostic = per[25:18];
  wire o_serial_a_receive, o_serial_b_receive, o_sync_serial_data_input;
  wire o_sync_serial_clock_in, o_sync_serial_enable_in, o_two_wire_clock_in;
  wire o_two_wire_data_in, o_serial_a_infrared_receive, o_serial_b_infrared_receive;
  wire o_serial_a_clear_to_send_n, o_serial_b_clear_to_send_n;
  int fail_count = 0, n_compared = 0, cyc = 0;
  // Peripheral outputs come from the far-side model as one bundle
  assign {i_serial_b_request_to_send_n, i_serial_a_request_to_send_n, i_pulse_width_out_four,
    i_pulse_width_out_three, i_pulse_width_out_two, i_pulse_width_out_one,
    i_pulse_width_out_zero, i_serial_b_infrared_transmit, i_serial_a_infrared_transmit,
    i_two_wire_data_low, i_two_wire_clock_low, i_sync_serial_enable_oe,
    i_sync_serial_enable_out, i_sync_serial_clock_oe, i_sync_serial_clock_out,
    i_sync_serial_data_output, i_serial_b_transmit, i_serial_a_transmit} = per[17:0];
  // Input channels in the design's channel order
  wire [10:0] chan = {o_serial_b_clear_to_send_n, o_serial_a_clear_to_send_n,
    o_serial_b_infrared_receive, o_serial_a_infrared_receive, o_two_wire_data_in,
    o_two_wire_clock_in, o_sync_serial_enable_in, o_sync_serial_clock_in,
    o_sync_serial_data_input, o_serial_b_receive, o_serial_a_receive};

  p0pmm_mux p0pmm_mux_i (.*);
  p0pmm_far_side p0pmm_far_side_i (.i_clock, .i_stir(stir), .i_ext_drive(ext_drive),
    .i_ext_level(ext_level), .i_pad_out(o_pad_out), .i_pad_oe_n(o_pad_oe_n),
    .i_pull_up(o_pad_pull_up), .i_pull_down(o_pad_pull_down), .o_pad_in(i_pad_in),
    .o_periph(per));

  initial begin
    forever #20 i_clock = ~i_clock;
  end
  // Cut a hang short; the whole run needs well under this
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  function automatic [31:0] ma(input int k);
    ma = 32'h5000300c + 2 * k;
  endfunction
  function automatic [15:0] mw(input [1:0] pu, input [4:0] f);
    mw = {6'h00, pu, 3'h0, f};
  endfunction
  function automatic logic out_exp(input int c, input int k, input [25:0] p);
    case (c)
      2: out_exp = p[0];  4: out_exp = p[1];  6: out_exp = p[2];
      12: out_exp = p[9]; 14: out_exp = p[10]; 16: out_exp = p[11];
      17: out_exp = p[12]; 23: out_exp = p[13]; 24: out_exp = p[14];
      25: out_exp = p[15]; 20: out_exp = p[16]; 22: out_exp = p[17];
      18: out_exp = p[21 + k];
      default: out_exp = 1'b0;
    endcase
  endfunction
  function automatic int chan_of(input int c);
    case (c)
      1: chan_of = 0;  3: chan_of = 1;  5: chan_of = 2;  7: chan_of = 3;
      8: chan_of = 4;  9: chan_of = 5;  10: chan_of = 6; 11: chan_of = 7;
      13: chan_of = 8; 19: chan_of = 9; default: chan_of = 10;
    endcase
  endfunction

  task automatic wr(input [31:0] a, input [15:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_write_data <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input [31:0] a, output [15:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 d = o_read_data;
  endtask
  task automatic settle();
    repeat (3) @(posedge i_clock);
    #1;
  endtask
  task automatic clr();
    for (int k = 0; k < 4; k++) wr(ma(k), 16'h0200);
    settle();
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    logic [15:0] d, r;
    logic [1:0] pu;
    int k, f;
    logic lv;
    static int outs[13] = '{2, 4, 6, 12, 14, 16, 17, 18, 20, 22, 23, 24, 25};
    static int ins[11] = '{1, 3, 5, 7, 8, 9, 10, 11, 13, 19, 21};
    void'($urandom(32'h9c81001d));
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    settle();
    `CHECK({o_pad_oe_n, o_pad_pull_down, o_pad_pull_up}, 12'hff0)
    `CHECK(chan, `P0PMM_INPUT_IDLE)
    for (k = 0; k < 4; k++) begin
      rd(ma(k), r);
      `CHECK(r, 16'h0200)
    end
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      wr(ma(k), d);
      rd(ma(k), r);
      `CHECK(r, d & 16'h031f)
    end
    rd(32'h50003014, r);
    `CHECK(r, 16'h0000)
    rd(32'h5000300a, r);
    `CHECK(r, 16'h0000)
    clr();
    $display("test registers done");
    repeat (16) begin
      k = $urandom % 4;
      pu = $urandom;
      f = $urandom % 7;
      if (f != 0) f = f + 25;
      i_port_out <= $urandom;
      wr(ma(k), mw(pu, f));
      settle();
      `CHECK(o_pad_oe_n[k], pu != 2'h3)
      `CHECK({o_pad_pull_up[k], o_pad_pull_down[k]}, {pu == 2'h1, pu == 2'h2})
      if (pu == 2'h3) `CHECK(o_pad_out[k], i_port_out[k])
      wr(ma(k), 16'h0200);
    end
    settle();
    $display("test port mode done");
    foreach (outs[i]) begin
      k = $urandom % 4;
      stir <= $urandom;
      wr(ma(k), mw($urandom, outs[i]));
      settle();
      `CHECK(o_pad_oe_n[k], 1'b0)
      `CHECK(o_pad_out[k], out_exp(outs[i], k, per))
      wr(ma(k), 16'h0200);
    end
    settle();
    $display("test outputs done");
    ext_drive <= 4'hf;
    foreach (ins[i]) begin
      k = $urandom % 4;
      lv = $urandom;
      stir <= $urandom & 26'h3fffe2f;
      ext_level <= {4{lv}};
      wr(ma(k), mw(2'h0, ins[i]));
      settle();
      `CHECK(chan[chan_of(ins[i])], lv)
      ext_level <= {4{~lv}};
      settle();
      `CHECK(chan[chan_of(ins[i])], ~lv)
      wr(ma(k), 16'h0200);
      settle();
      `CHECK(chan, `P0PMM_INPUT_IDLE)
    end
    $display("test inputs done");
    wr(ma(1), mw(2'h0, 5'h01));
    wr(ma(2), mw(2'h0, 5'h01));
    ext_level <= 4'b0010;
    settle();
    `CHECK(o_serial_a_receive, 1'b1)
    `CHECK(o_claim, 11'h001)
    ext_level <= 4'b0100;
    settle();
    `CHECK(o_serial_a_receive, 1'b0)
    ext_level <= 4'b0010;
    i_higher_claim <= 11'h001;
    settle();
    `CHECK(o_serial_a_receive, 1'b0)
    i_higher_level <= 11'h001;
    ext_level <= 4'b0000;
    settle();
    `CHECK(o_serial_a_receive, 1'b1)
    i_higher_claim <= 11'h000;
    ext_drive <= 4'h0;
    clr();
    $display("test priority done");
    pu = $urandom;
    wr(ma(0), mw(pu, 5'h0f));
    wr(ma(2), mw(pu, 5'h0f));
    settle();
    `CHECK(o_pad_analog, 4'h1)
    `CHECK({o_pad_pull_up[0], o_pad_pull_down[0]}, 2'h0)
    `CHECK(o_pad_oe_n[2], pu != 2'h3)
    rd(32'h50003040, r);
    `CHECK({r[15:8], r[7:4]}, 12'h001)
    clr();
    $display("test analog done");
    // Reset in mid-run must bring a driving pin back to its start state
    wr(ma(1), 16'h0302);
    settle();
    `CHECK(o_pad_oe_n[1], 1'b0)
    i_reset <= 1'b1;
    @(posedge i_clock);
    i_reset <= 1'b0;
    settle();
    `CHECK(o_pad_oe_n, 4'hf)
    rd(ma(1), r);
    `CHECK(r, 16'h0200)
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
`default_nettype wire
